// ---- dv/carrier_far_end.sv ----
// Far-end model: carrier bursts, resync strap and time-of-day divider
`timescale 1ns/1ps
`default_nettype none
module carrier_far_end (
  input  wire logic       clock,
  input  wire logic       fire,
  input  wire logic [5:0] burstLen,
  input  wire logic       roleStrap,
  input  wire logic       resyncOut,
  input  wire logic       epochClock,
  input  wire logic       timeStdReset,
  output logic            detectedCarrier,
  output logic            counterInit,
  output logic [7:0]      todCount
);
  logic [5:0] left = 6'h00;
  logic       epochPrev = 1'b0;
  // ==========================================
  // Strap and carrier
  // Slave strap loops resync back into init
  assign counterInit = roleStrap & resyncOut;
  // Burst of carrier, high while on, low when idle
  always_ff @(posedge clock)
  begin
    if (fire)
      left <= burstLen;
    else if (left != 6'h00)
      left <= left - 6'h01;
    detectedCarrier <= fire || left > 6'h01;
  end
  // ==========================================
  // Time of day
  // Divide epochs by 192, cleared by the standard pulse
  always_ff @(posedge clock)
  begin
    epochPrev <= epochClock;
    if (timeStdReset)
      todCount <= 8'h00;
    else if (epochClock && !epochPrev)
      todCount <= (todCount == 8'hBF) ? 8'h00 : todCount + 8'h01;
  end
endmodule // carrier_far_end
`default_nettype wire

// ---- dv/epoch_divider_sync_test.sv ----
// Testbench for the epoch divider: slave sync, timeout, bus and master timing
`timescale 1ns/1ps
`default_nettype none
`include "epoch_divider_sync_cfg.svh"
module epoch_divider_sync_test
  import epoch_divider_sync_pkg::*;
;
  localparam int T1 = 0, RS = 1, TO = 2, CE = 3, TX = 4, DI = 5;
  axi_req_t    axiIn;
  axi_rsp_t    axiOut;
  logic        clock, sys_rst, detectedCarrier, counterInit, timeStdReset, roleStrap, fire;
  logic        resyncOut, frameSyncPulse, syncTimeout, txSelect, roomTrackHold, antennaTrackHold;
  logic        carrierEnable, dataInvalidFlag, syncErrorOut, tick300kIrregular, epochClock;
  logic [3:0]  tick100k;
  logic [5:0]  burstLen;
  logic [31:0] a, p0, p1;
  logic [1:0]  r;
  int          numErrors, totalChecks, n, k;
  wire  [5:0]  obs = {dataInvalidFlag, txSelect, carrierEnable, syncTimeout, resyncOut, tick100k[0]};
  // ==========================================
  // Design and far end
  epoch_divider_sync #(.LOSS_CYCLES(200), .HOLD_CYCLES(50)) epoch_divider_sync_i (.clock, .sys_rst, .axiIn,
    .axiOut, .detectedCarrier, .counterInit, .timeStdReset, .roleStrap, .resyncOut, .frameSyncPulse,
    .syncTimeout, .txSelect, .roomTrackHold, .antennaTrackHold, .carrierEnable, .dataInvalidFlag,
    .syncErrorOut, .tick100k, .tick300kIrregular, .epochClock);
  carrier_far_end carrier_far_end_i (.clock, .fire, .burstLen, .roleStrap, .resyncOut, .epochClock,
    .timeStdReset, .detectedCarrier, .counterInit, .todCount());
  // ==========================================
  // Helpers
  task automatic endSim;
    if (numErrors == 0 && totalChecks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    totalChecks++;
    if (g !== e)
    begin
      numErrors++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic waitFor(input int s, input logic v, input int lim, output int c);
    c = 0;
    while (obs[s] !== v && c < lim)
    begin
      @(negedge clock);
      c++;
    end
  endtask
  task automatic axiWrite(input logic [31:0] ad, input logic [31:0] d, input logic [1:0] e);
    logic aw, w, b;
    @(posedge clock);
    axiIn.awaddr <= ad;
    axiIn.awvalid <= 1'b1;
    axiIn.wdata <= d;
    axiIn.wstrb <= 4'hF;
    axiIn.wvalid <= 1'b1;
    axiIn.bready <= 1'b1;
    forever
    begin
      @(negedge clock);
      aw = axiIn.awvalid && axiOut.awready;
      w = axiIn.wvalid && axiOut.wready;
      b = axiOut.bvalid;
      r = axiOut.bresp;
      @(posedge clock);
      if (aw) axiIn.awvalid <= 1'b0;
      if (w) axiIn.wvalid <= 1'b0;
      if (b)
      begin
        axiIn.bready <= 1'b0;
        break;
      end
    end
    chk("write resp", e, r);
  endtask
  task automatic axiRead(input logic [31:0] ad, output logic [31:0] d);
    logic ar, rv;
    @(posedge clock);
    axiIn.araddr <= ad;
    axiIn.arvalid <= 1'b1;
    axiIn.rready <= 1'b1;
    forever
    begin
      @(negedge clock);
      ar = axiIn.arvalid && axiOut.arready;
      rv = axiOut.rvalid;
      d = axiOut.rdata;
      r = axiOut.rresp;
      @(posedge clock);
      if (ar) axiIn.arvalid <= 1'b0;
      if (rv)
      begin
        axiIn.rready <= 1'b0;
        break;
      end
    end
  endtask
  task automatic rdChk(input string nm, input logic [31:0] ad, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] d;
    axiRead(ad, d);
    chk(nm, e, d & m);
    chk("read resp", (ad[31:4] != 28'h0) ? `RESP_SLVERR : `RESP_OKAY, r);
  endtask
  task automatic burst;
    @(posedge clock);
    burstLen <= 6'h08 + 6'($urandom_range(30, 0));
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
  endtask
  // ==========================================
  // Clock and watchdog
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial
  begin
    repeat (95000) @(posedge clock);
    numErrors++;
    endSim();
  end
  // ==========================================
  // Main sequence
  initial
  begin
    axiIn = '0;
    {sys_rst, roleStrap, fire, burstLen, timeStdReset} = {2'h3, 8'h00};
    void'($urandom(32'hF323));
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clock);
    chk("sync error", 1'b1, syncErrorOut);
    rdChk("status", `REG_STATUS, 32'hFF09, 32'hFF09);
    for (int i = 0; i < 3; i++)
    begin
      axiWrite(`REG_CONTROL, 32'h1, `RESP_OKAY);
      burst();
      waitFor(RS, 1'b1, 40, n);
      chk("resync seen", 1'b1, n < 40);
      waitFor(RS, 1'b0, 100, n);
      chk("resync width", 32'h14, n);
      rdChk("position", `REG_POSITION, 32'hFFFE, 32'h0);
      chk("slave receive", 1'b0, txSelect);
      chk("antenna hold", 1'b0, antennaTrackHold);
    end
    repeat (1200) @(posedge clock);
    rdChk("history", `REG_STATUS, 32'hFF01, 32'h7F01);
    burst();
    waitFor(RS, 1'b1, 60, n);
    chk("no resync", 32'h3C, n);
    waitFor(TO, 1'b0, 100, n);
    waitFor(TO, 1'b1, 300, n);
    chk("timeout seen", 1'b1, n < 300);
    repeat (2) @(negedge clock);
    chk("forced receive", 1'b0, txSelect);
    waitFor(TO, 1'b0, 100, n);
    chk("timeout length", 32'h30, n);
    a = ($urandom << 4) | 32'h10;
    axiWrite(a, $urandom, `RESP_SLVERR);
    rdChk("unmapped", a, 32'hFFFFFFFF, 32'h0);
    axiWrite(`REG_STATUS, 32'hFFFFFFFF, `RESP_OKAY);
    roleStrap <= 1'b0;
    repeat (8) @(posedge clock);
    chk("master error", 1'b0, syncErrorOut);
    rdChk("master status", `REG_STATUS, 32'hFF02, 32'h0002);
    burst();
    waitFor(RS, 1'b1, 60, n);
    chk("master resync", 32'h3C, n);
    timeStdReset <= 1'b1;
    repeat ($urandom_range(6, 2)) @(posedge clock);
    timeStdReset <= 1'b0;
    repeat (8) @(posedge clock);
    rdChk("aligned", `REG_POSITION, 32'hFFFE, 32'h0);
    chk("epoch level", 1'b1, epochClock);
    chk("carrier on", 1'b1, carrierEnable);
    chk("transmit", 1'b1, txSelect);
    chk("invalid", 1'b1, dataInvalidFlag);
    chk("hold", 1'b0, roomTrackHold);
    chk("frame idle", 1'b0, frameSyncPulse);
    axiWrite(`REG_CONTROL, 32'h3, `RESP_OKAY);
    rdChk("control", `REG_CONTROL, 32'hFFFFFFFF, 32'h2);
    repeat (2) @(negedge clock);
    chk("forced rx", 1'b0, txSelect);
    axiWrite(`REG_CONTROL, 32'h0, `RESP_OKAY);
    chk("copies", 1'b1, tick100k == 4'h0 || tick100k == 4'hF);
    waitFor(T1, 1'b0, 600, n);
    waitFor(T1, 1'b1, 600, n);
    chk("tick low", 32'hFA, n);
    waitFor(T1, 1'b0, 600, n);
    chk("tick high", 32'hFA, n);
    k = 0;
    repeat (500)
    begin
      @(negedge clock);
      k += int'(tick300kIrregular);
    end
    chk("burst count", 32'h3, k);
    axiRead(`REG_POSITION, p0);
    repeat (5000) @(posedge clock);
    axiRead(`REG_POSITION, p1);
    chk("advance", 32'h1E, p1 - p0);
    waitFor(CE, 1'b0, 60000, n);
    rdChk("carrier end", `REG_POSITION, 32'h3FFF, 32'h12C);
    waitFor(TX, 1'b0, 2000, n);
    rdChk("transmit end", `REG_POSITION, 32'h3FFF, 32'h130);
    chk("track", 1'b1, roomTrackHold);
    waitFor(DI, 1'b0, 30000, n);
    rdChk("invalid end", `REG_POSITION, 32'h3FFF, 32'h1C1);
    endSim();
  end
endmodule // epoch_divider_sync_test
`default_nettype wire

// ---- verilog/epoch_divider_sync.sv ----
// Epoch divider with slave resynchronisation and an AXI4-Lite register slave
//
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "epoch_divider_sync_cfg.svh"

module epoch_divider_sync
  import epoch_divider_sync_pkg::*;
#(
  parameter int unsigned LOSS_CYCLES = `S_TO_CYCLES(`LOSS_S),
  parameter int unsigned HOLD_CYCLES = `S_TO_CYCLES(`HOLD_S)
)(
  input  wire logic       clock,
  input  wire logic       sys_rst,
  input  wire axi_req_t   axiIn,
  output var  axi_rsp_t   axiOut,
  input  wire logic       detectedCarrier,
  input  wire logic       counterInit,
  input  wire logic       timeStdReset,
  input  wire logic       roleStrap,
  output logic            resyncOut,
  output logic            frameSyncPulse,
  output logic            syncTimeout,
  output logic            txSelect,
  output logic            roomTrackHold,
  output logic            antennaTrackHold,
  output logic            carrierEnable,
  output logic            dataInvalidFlag,
  output logic            syncErrorOut,
  output logic [3:0]      tick100k,
  output logic            tick300kIrregular,
  output logic            epochClock
);

  // ==========================================================
  // Derived constants
  localparam logic [3:0]  PRE_LAST  = 4'(`PRE_DIV - 1);
  localparam logic [5:0]  DIV_LAST  = 6'(`DIV_100K - 1);
  localparam logic [5:0]  DIV_HALF  = 6'(`DIV_100K / 2);
  localparam logic [13:0] LAST      = 14'(`EPOCH_LEN - 1);
  localparam logic [13:0] LEAD_AT   = 14'(`EPOCH_LEN - `US_TO_TICKS(`TX_LEAD_US));
  localparam logic [13:0] CMD_END   = 14'(`US_TO_TICKS(`CMD_US));
  localparam logic [13:0] TX_END    = 14'(`US_TO_TICKS(`CMD_US + `TX_TAIL_US));
  localparam logic [13:0] INV_END   = 14'(`US_TO_TICKS(`INV_END_US));
  localparam logic [13:0] WIN_AT    = 14'(`EPOCH_LEN - `US_TO_TICKS(`WIN_US));
  localparam logic [13:0] MATCH_AT  = 14'(`MATCH_TICKS);
  localparam logic [13:0] HALF_EP   = 14'(`EPOCH_LEN / 2);
  localparam logic [4:0]  FS_LOAD   = 5'(`FS_CYCLES);

  // Refuse timer lengths the one-shot cannot serve
  if (LOSS_CYCLES < 2 || HOLD_CYCLES < 2)
  begin : g_bad_timer
    $error("Timeout lengths must be at least two cycles");
  end

  state_t s;
  state_t next;
  logic   tick5;
  logic   fall100k;
  logic   tick300;
  logic   initEvent;
  logic   dcRise;
  logic   isMaster;
  logic   txWin;
  logic   winOpen;
  logic   compareEvent;
  logic   acquire;
  logic   wMapped;
  logic   rMapped;

  // Three-flop filter: accept a new level once stages two and three agree
  function automatic logic filt(input logic [2:0] q, input logic lvl);
    filt = (q[2] == q[1]) ? q[2] : lvl;
  endfunction

  // ==========================================================
  // Event decode from present state
  assign tick5        = (s.pre == PRE_LAST);
  assign fall100k     = tick5 && (s.div50 == DIV_HALF - 6'h01);            // see RL13
  assign tick300      = tick5 && (s.burst != 2'h0);                        // see RL13
  assign initEvent    = (s.ciLevel && !s.ciPrev) || (s.tsLevel && !s.tsPrev); // see RL16
  assign dcRise       = s.dcLevel && !s.dcPrev;                            // see RL21
  assign isMaster     = !s.stLevel;                                        // see RL6
  assign txWin        = (s.epochCount >= LEAD_AT) || (s.epochCount < TX_END);  // see RL23
  assign winOpen      = (s.epochCount >= WIN_AT) || (s.epochCount < MATCH_AT); // see RL20
  assign compareEvent = tick300 && (s.epochCount == MATCH_AT) && !isMaster;
  assign acquire      = (s.syncHistoryRegister == 8'hFF);
  assign wMapped      = (s.awAddr[31:4] == 28'h0000000);
  assign rMapped      = (axiIn.araddr[31:4] == 28'h0000000);

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    next = s;
    // Pin synchronisers
    next.dcSync  = {s.dcSync[1:0], detectedCarrier};
    next.ciSync  = {s.ciSync[1:0], counterInit};
    next.tsSync  = {s.tsSync[1:0], timeStdReset};
    next.stSync  = {s.stSync[1:0], roleStrap};
    next.dcLevel = filt(s.dcSync, s.dcLevel);
    next.ciLevel = filt(s.ciSync, s.ciLevel);
    next.tsLevel = filt(s.tsSync, s.tsLevel);
    next.stLevel = filt(s.stSync, s.stLevel);
    next.dcPrev  = s.dcLevel;
    next.ciPrev  = s.ciLevel;
    next.tsPrev  = s.tsLevel;

    // 5 MHz reference tick and divide-by-50
    next.pre = tick5 ? 4'h0 : s.pre + 4'h1;
    if (tick5)
    begin
      next.div50 = (s.div50 == DIV_LAST) ? 6'h00 : s.div50 + 6'h01;        // see RL12
    end
    // Three-pulse multiplier
    if (fall100k)
    begin
      next.burst = 2'(`BURST_LEN);                                        // see RL13
    end
    else if (tick300)
    begin
      next.burst = s.burst - 2'h1;
    end
    // Divide-by-15625 epoch counter
    if (tick300)
    begin
      next.epochCount = (s.epochCount == LAST) ? 14'h0000 : s.epochCount + 14'h0001; // see RL14
    end
    if (tick300 && s.epochCount == LAST)
    begin
      next.epochs = s.epochs + 32'h00000001;
    end
    // Counter init or time standard realigns both counters
    if (initEvent)
    begin
      next.div50      = 6'h00;                                            // see RL16
      next.burst      = 2'h0;
      next.epochCount = 14'h0000;                                         // see RL1
    end
    next.clk100k = (next.div50 < DIV_HALF);                              // see RL12
    next.tick300 = tick300;

    // Frame sync pulse at each epoch start
    if (tick300 && s.epochCount == LAST)
    begin
      next.fsCount = FS_LOAD;                                             // see RL3
    end
    else if (s.fsCount != 5'h00)
    begin
      next.fsCount = s.fsCount - 5'h01;
    end
    next.frameSync = (next.fsCount != 5'h00);

    // Decoded timing outputs
    if (isMaster)
    begin
      next.txSelect = txWin && !s.forceRx;                                // see RL5
    end
    else
    begin
      next.txSelect = !txWin && !s.forcing && !s.forceRx;                 // see RL22
    end
    next.roomTrackHold    = isMaster && !txWin;                           // see RL7
    next.antennaTrackHold = !isMaster && !txWin;
    next.carrierEnable    = isMaster && (s.epochCount < CMD_END);         // see RL8
    next.dataInvalid      = isMaster && ((s.epochCount >= LEAD_AT) || (s.epochCount < INV_END)); // see RL24
    next.epochClock       = (s.epochCount < HALF_EP);

    // Sync comparison, done before latching so a late edge survives
    if (compareEvent)
    begin
      if (s.received)
      begin
        next.syncHistoryRegister = {1'b0, s.syncHistoryRegister[7:1]};   // see RL18
      end
      else
      begin
        next.syncHistoryRegister = {s.syncHistoryRegister[6:0], 1'b1};   // see RL18
      end
      next.received = 1'b0;
    end
    // Leading-edge latch and acquisition resync
    if (!isMaster && dcRise && acquire)
    begin
      next.resyncCount = FS_LOAD;                                         // see RL15
      next.received    = 1'b1;
    end
    else if (!isMaster && dcRise && winOpen)
    begin
      next.received = 1'b1;                                               // see RL20
    end
    else if (s.resyncCount != 5'h00)
    begin
      next.resyncCount = s.resyncCount - 5'h01;
    end
    next.resync = (next.resyncCount != 5'h00);

    // Loss-of-sync one-shot
    if (!isMaster && s.syncError)
    begin
      if (s.forcing)
      begin
        next.holdCount = s.holdCount + 32'h00000001;
        if (s.holdCount == HOLD_CYCLES - 1)
        begin
          next.forcing   = 1'b0;                                          // see RL22
          next.lossCount = 32'h00000000;
        end
      end
      else
      begin
        next.lossCount = s.lossCount + 32'h00000001;
        if (s.lossCount == LOSS_CYCLES - 1)
        begin
          next.forcing   = 1'b1;                                          // see RL22
          next.holdCount = 32'h00000000;
        end
      end
    end
    else
    begin
      next.lossCount = 32'h00000000;
      next.forcing   = 1'b0;
    end

    // AXI4-Lite write channels
    if (!s.awHave && axiIn.awvalid)
    begin
      next.awHave = 1'b1;
      next.awAddr = axiIn.awaddr;
    end
    if (!s.wHave && axiIn.wvalid)
    begin
      next.wHave = 1'b1;
      next.wData = axiIn.wdata;
      next.wStrb = axiIn.wstrb;
    end
    if (s.bValid && axiIn.bready)
    begin
      next.bValid = 1'b0;
    end
    if (s.awHave && s.wHave && !s.bValid)
    begin
      next.awHave = 1'b0;
      next.wHave  = 1'b0;
      next.bValid = 1'b1;
      next.bResp  = wMapped ? `RESP_OKAY : `RESP_SLVERR;
      if (wMapped && s.awAddr[3:0] == `REG_CONTROL && s.wStrb[0])
      begin
        next.forceRx = s.wData[`CTL_FORCE_BIT];
        if (s.wData[`CTL_REINIT_BIT])
        begin
          next.syncHistoryRegister = `HISTORY_RESET;
        end
      end
    end
    // Master never loses sync
    if (isMaster)
    begin
      next.syncHistoryRegister = 8'h00;
      next.received            = 1'b0;
    end
    // Error flag with hysteresis
    if (next.syncHistoryRegister == 8'hFF)
    begin
      next.syncError = 1'b1;                                              // see RL25
    end
    else if (next.syncHistoryRegister == 8'h00)
    begin
      next.syncError = 1'b0;                                              // see RL19
    end

    // AXI4-Lite read channels
    if (s.rValid && axiIn.rready)
    begin
      next.rValid = 1'b0;
    end
    if (!s.rValid && axiIn.arvalid)
    begin
      next.rValid = 1'b1;
      next.rResp  = rMapped ? `RESP_OKAY : `RESP_SLVERR;
      next.rData  = 32'h00000000;
      if (rMapped)
      begin
        case (axiIn.araddr[3:0])
          `REG_CONTROL:  next.rData = {30'h00000000, s.forceRx, 1'b0};
          `REG_STATUS:   next.rData = {16'h0000, s.syncHistoryRegister, 4'h0, acquire, s.forcing,
                                       isMaster, s.syncError};
          `REG_POSITION: next.rData = {18'h00000, s.epochCount};
          `REG_EPOCHS:   next.rData = s.epochs;
          default:       next.rData = 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // State register, synchronous reset
  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      s                     <= '0;
      s.clk100k             <= 1'b1;
      s.stLevel             <= 1'b1;
      s.stSync              <= 3'h7;
      s.syncHistoryRegister <= `HISTORY_RESET;
      s.syncError           <= 1'b1;
    end
    else
    begin
      s <= next;
    end
  end

  // ==========================================================
  // Outputs
  assign axiOut.awready    = !s.awHave;
  assign axiOut.wready     = !s.wHave;
  assign axiOut.bvalid     = s.bValid;
  assign axiOut.bresp      = s.bResp;
  assign axiOut.arready    = !s.rValid;
  assign axiOut.rvalid     = s.rValid;
  assign axiOut.rdata      = s.rData;
  assign axiOut.rresp      = s.rResp;
  assign resyncOut         = s.resync;                                    // see RL17
  assign frameSyncPulse    = s.frameSync;
  assign syncTimeout       = s.forcing;                                   // see RL4
  assign txSelect          = s.txSelect;
  assign roomTrackHold     = s.roomTrackHold;
  assign antennaTrackHold  = s.antennaTrackHold;
  assign carrierEnable     = s.carrierEnable;
  assign dataInvalidFlag   = s.dataInvalid;                               // see RL9
  assign syncErrorOut      = s.syncError && s.stLevel;                    // see RL10
  assign tick100k          = {4{s.clk100k}};                              // see RL11
  assign tick300kIrregular = s.tick300;
  assign epochClock        = s.epochClock;                                // see RL2

  // ==========================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  frame_width_a: assert property ($rose(s.frameSync) |-> s.frameSync [*8] ##13 !s.frameSync) // see RL3
    else $error("Frame sync width wrong");
  burst_three_a: assert property (disable iff (sys_rst || initEvent) // see RL13
    fall100k && !initEvent |=> !tick300 [*8] ##2 tick300 ##10 tick300 ##10 tick300)
    else $error("Multiplier burst wrong");
  epoch_wrap_a: assert property (tick300 && s.epochCount == LAST && !initEvent |=> s.epochCount == 14'h0000) // see RL14
    else $error("Epoch counter did not wrap");
  init_clear_a: assert property (initEvent |=> s.div50 == 6'h00 && s.epochCount == 14'h0000) // see RL16
    else $error("Counter init ignored");
  resync_pulse_a: assert property (!isMaster && dcRise && acquire |=> s.resync [*8]) // see RL15
    else $error("No resync pulse in acquisition");
  shift_good_a: assert property (compareEvent && s.received && !isMaster && !s.bValid && !(s.awHave && s.wHave)
    |=> s.syncHistoryRegister == {1'b0, $past(s.syncHistoryRegister[7:1])}) // see RL18
    else $error("Good comparison not shifted right");
  shift_bad_a: assert property (compareEvent && !s.received && !(s.awHave && s.wHave)
    |=> s.syncHistoryRegister == {$past(s.syncHistoryRegister[6:0]), 1'b1}) // see RL18
    else $error("Bad comparison not shifted left");
  error_hyst_a: assert property ($changed(s.syncError) |-> s.syncHistoryRegister == (s.syncError ? 8'hFF : 8'h00)) // see RL25
    else $error("Sync error changed without full history");
  latch_window_a: assert property ($rose(s.received) |-> $past(winOpen) || $past(acquire)) // see RL20
    else $error("Sync latched outside window");
  master_tx_a: assert property (isMaster && !s.forceRx && $past(isMaster) && txWin ##1 isMaster |-> s.txSelect) // see RL23
    else $error("Master transmit-select low in window");
  invalid_span_a: assert property (isMaster && s.epochCount == INV_END - 14'h0001 ##1 isMaster |-> s.dataInvalid) // see RL24
    else $error("Data invalid dropped early");
  forced_rx_a: assert property (s.forcing && !isMaster |=> !s.txSelect) // see RL22
    else $error("Modem not forced to receive");

  frame_seen_c:  cover property ($rose(s.frameSync));
  sync_gain_c:   cover property ($fell(s.syncError));
  timeout_c:     cover property ($rose(s.forcing));
  bus_write_c:   cover property (s.bValid && axiIn.bready && s.bResp == `RESP_OKAY);

endmodule // epoch_divider_sync
`default_nettype wire

// ---- verilog/epoch_divider_sync_cfg.svh ----
// Constants for the epoch divider: offsets, field positions, reset values and timing counts
// Functional notes
// RL1: A time-standard reset pulse realigns the epoch ticks with standard time.
// RL2: The time-of-day clock divides the epoch to 0.1 Hz, cleared by that pulse.
// RL3: Frame sync output is a 400 ns positive pulse once per epoch.
// RL4: Antenna unit drives sync timeout high on error, low otherwise.
// RL5: Transmit-select is high for modem transmit, low for receive.
// RL6: Role strap low selects master, open selects antenna slave.
// RL7: Room and antenna track/hold outputs are high to track, low to hold.
// RL8: Carrier enable and detected carrier are active high, high meaning carrier on.
// RL9: Data-invalid output is high whenever delay-line data may be invalid.
// RL10: Antenna sync error output is high while out of sync.
// RL11: Antenna provides the 100 kHz clock on four separate outputs.
// RL12: Shaped 5 MHz clock feeds a divide-by-50 giving a 100 kHz square wave.
// RL13: Each 100 kHz falling edge emits three 5 MHz pulses, averaging 300 kHz.
// RL14: A divide-by-15625 on the 300 kHz clock makes the epoch; decodes drive outputs.
// RL15: In acquisition, each detected-carrier rising edge produces a resync pulse.
// RL16: A counter-init pulse initialises the divide-by-50 and divide-by-15625 counters.
// RL17: In a slave, resync output is strapped to counter-init input.
// RL18: Matching sync shifts a zero right into history; mismatch shifts a one left.
// RL19: Eight good comparisons achieve sync, eight bad ones lose it.
// RL20: Sync latch captures the leading edge, enabled from 25 us before predicted sync.
// RL21: Only the rising edge of received sync enters the comparison.
// RL22: After 20 s continuous loss of sync, force antenna modems to receive for 1 s.
// RL23: Master transmit-select rises 106 us before command time, falls 16 us after.
// RL24: Data-invalid spans from 106 us before the epoch reference to 1497 us after.
// RL25: Sync error sets when history is all ones, clears only when all zeros.
`ifndef EPOCH_DIVIDER_SYNC_CFG_SVH
`define EPOCH_DIVIDER_SYNC_CFG_SVH

// ==========================================================
// Clock and divider figures
`define CLK_MHZ        50
`define REF_MHZ        5
`define PRE_DIV        (`CLK_MHZ / `REF_MHZ)
`define DIV_100K       50
`define BURST_LEN      3
`define EPOCH_LEN      15625
`define TICK_KHZ       300

// ==========================================================
// Times in their own units and derived counts
`define FS_NS          400
`define FS_CYCLES      ((`FS_NS * `CLK_MHZ + 999) / 1000)
`define US_TO_TICKS(u) (((u) * `TICK_KHZ) / 1000)
`define TX_LEAD_US     106
`define CMD_US         1000
`define TX_TAIL_US     16
`define INV_END_US     1497
`define WIN_US         25
`define MATCH_TICKS    2
`define LOSS_S         20
`define HOLD_S         1
`define S_TO_CYCLES(s) ((s) * `CLK_MHZ * 1000000)

// ==========================================================
// Register byte offsets and fields
`define REG_CONTROL    4'h0
`define REG_STATUS     4'h4
`define REG_POSITION   4'h8
`define REG_EPOCHS     4'hC
`define CTL_REINIT_BIT 0
`define CTL_FORCE_BIT  1
`define ST_ERR_BIT     0
`define ST_MASTER_BIT  1
`define ST_FORCE_BIT   2
`define ST_ACQ_BIT     3
`define ST_HIST_LSB    8
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define HISTORY_RESET  8'hFF

`endif

// ---- verilog/epoch_divider_sync_pkg.sv ----
// Types shared by the epoch divider: bus carriers and the state record
package epoch_divider_sync_pkg;

  // AXI4-Lite request from the master
  typedef struct packed {
    logic [31:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [31:0] araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_t;

  // AXI4-Lite answer from the slave
  typedef struct packed {
    logic        awready;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
  } axi_rsp_t;

  // Whole state of the divider
  typedef struct packed {
    logic [3:0]  pre;
    logic [5:0]  div50;
    logic        clk100k;
    logic [1:0]  burst;
    logic [13:0] epochCount;
    logic [4:0]  fsCount;
    logic        frameSync;
    logic [2:0]  dcSync;
    logic [2:0]  ciSync;
    logic [2:0]  tsSync;
    logic [2:0]  stSync;
    logic        dcLevel;
    logic        ciLevel;
    logic        tsLevel;
    logic        stLevel;
    logic        dcPrev;
    logic        ciPrev;
    logic        tsPrev;
    logic        received;
    logic [7:0]  syncHistoryRegister;
    logic        syncError;
    logic [4:0]  resyncCount;
    logic        resync;
    logic [31:0] lossCount;
    logic [31:0] holdCount;
    logic        forcing;
    logic        txSelect;
    logic        roomTrackHold;
    logic        antennaTrackHold;
    logic        carrierEnable;
    logic        dataInvalid;
    logic        epochClock;
    logic        tick300;
    logic        forceRx;
    logic [31:0] epochs;
    logic        awHave;
    logic [31:0] awAddr;
    logic        wHave;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } state_t;

endpackage
